// ===== hw/xdata_steer_pkg.sv
// constants shared by the external-data access steering block
package xdata_steer_pkg;
  // ==========================================================
  // register map: printed offsets are indices, byte address = 4 * index
  localparam logic [7:0]  AUX_IDX        = 8'h8e;
  localparam logic [11:0] AUX_ADDR       = {2'h0, AUX_IDX, 2'h0};
  localparam logic [7:0]  STAT_IDX       = 8'h90;
  localparam logic [11:0] STAT_ADDR      = {2'h0, STAT_IDX, 2'h0};
  localparam logic [7:0]  AUX_RESET      = 8'h00;
  localparam logic [1:0]  AUX_IMPL_MASK  = 2'h3;
  localparam int          BYPASS_BIT     = 1;
  localparam int          LATCH_SUPP_BIT = 0;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_EXT_BIT   = 1;
  // ==========================================================
  // on-chip expanded ram window
  localparam int          ONCHIP_EXPANDED_RAM_DEPTH     = 768;
  localparam int          ONCHIP_EXPANDED_RAM_AW        = 10;
  localparam logic [15:0] ONCHIP_EXPANDED_RAM_BOUND     = 16'h0300;
  // ==========================================================
  // off-chip cycle phase lengths in pclk cycles
  localparam int          ADDR_CYCLES    = 2;
  localparam int          STRB_CYCLES    = 4;
  localparam int          HOLD_CYCLES    = 1;
  localparam int          CNT_W          = 4;
  // ==========================================================
  typedef enum logic [2:0] {
    S_IDLE, S_INT, S_ADDR, S_STRB, S_HOLD
  } steer_state_e;
endpackage

// ===== hw/onchip_expanded_ram_mem.sv
// single-port expanded data ram with registered read data
`timescale 1ns/1ns
`default_nettype none
module onchip_expanded_ram_mem #(
  parameter int DEPTH = 768,
  parameter int AW    = 10
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  // ==========================================================
  // storage: no reset, contents survive a system reset
  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && en && we) begin
      mem_r[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (ce && en) begin
      rdata <= we ? wdata : mem_r[addr];
    end
  end
endmodule // onchip_expanded_ram_mem
`default_nettype wire

// ===== hw/xdata_access_steering.sv
// steering of external-data moves between on-chip ram and the multiplexed bus
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module xdata_access_steering
  import xdata_steer_pkg::*;
#(
  parameter int ADDR_CYC = ADDR_CYCLES,
  parameter int STRB_CYC = STRB_CYCLES,
  parameter int HOLD_CYC = HOLD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core move datapath
  input  wire logic        mv_req,
  input  wire logic        mv_write,
  input  wire logic        mv_use_pointer,
  input  wire logic [15:0] mv_addr,
  input  wire logic [7:0]  mv_wdata,
  input  wire logic        code_byte_move,
  output logic             mv_ready,
  output logic             mv_done,
  output logic      [7:0]  mv_rdata,
  // external bus pins
  input  wire logic [7:0]  low_bus_port_i,
  output logic      [7:0]  low_bus_port_o,
  output logic             low_bus_port_oe,
  output logic      [7:0]  high_address_port_o,
  output logic             high_address_port_oe,
  output logic             wr_n,
  output logic             rd_n,
  output logic             ale
);
  // ==========================================================
  // phase ends
  localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(ADDR_CYC - 1);
  localparam logic [CNT_W-1:0] STRB_LAST = CNT_W'(STRB_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

  steer_state_e           st_r;
  logic [CNT_W-1:0]       cnt_r;
  logic [1:0]             aux_r;
  logic                   last_ext_r;
  logic [15:0]            cur_addr_r;
  logic [7:0]             cur_wdata_r;
  logic                   cur_write_r;
  logic                   cur_ptr_r;
  logic                   done_r;
  logic [7:0]             rdata_r;
  logic [31:0]            prdata_r;
  logic [7:0]             lbp_meta_r;
  logic [7:0]             lbp_sync_r;
  logic                   ale_r;
  logic [7:0]             lbp_o_r;
  logic                   lbp_oe_r;
  logic [7:0]             hap_o_r;
  logic                   hap_oe_r;
  logic                   wr_n_r;
  logic                   rd_n_r;
  logic                   bypass;
  logic                   latch_supp;
  logic                   accept;
  logic                   internal;
  logic                   acc_int;
  logic                   acc_ext;
  logic [ONCHIP_EXPANDED_RAM_AW-1:0]     ram_addr;
  logic [7:0]             ram_q;
  logic                   ale_idle;
  logic                   aux_hit;
  logic                   stat_hit;
  logic                   apb_wr;

  assign bypass     = aux_r[BYPASS_BIT];
  assign latch_supp = aux_r[LATCH_SUPP_BIT];

  // ==========================================================
  // request decode
  assign mv_ready = (st_r == S_IDLE) && !done_r && ce;
  assign accept   = mv_req && mv_ready;
  // register-indexed moves carry an 8-bit address, so they fall inside the ram unless bypass is set
  always_comb begin
    if (bypass) begin
      internal = 1'b0;
    end else if (mv_use_pointer) begin
      internal = (mv_addr < ONCHIP_EXPANDED_RAM_BOUND);
    end else begin
      internal = 1'b1;
    end
  end
  assign acc_int = accept && internal;
  assign acc_ext = accept && !internal;
  assign ram_addr = mv_use_pointer ? mv_addr[ONCHIP_EXPANDED_RAM_AW-1:0] : {2'b00, mv_addr[7:0]};

  onchip_expanded_ram_mem #(
    .DEPTH (ONCHIP_EXPANDED_RAM_DEPTH),
    .AW    (ONCHIP_EXPANDED_RAM_AW)
  ) u_onchip_expanded_ram (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .en    (acc_int),
    .we    (mv_write),
    .addr  (ram_addr),
    .wdata (mv_wdata),
    .rdata (ram_q)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= S_IDLE;
      cnt_r <= '0;
    end else if (ce) begin
      case (st_r)
        S_IDLE: begin
          cnt_r <= '0;
          if (acc_int) begin
            st_r <= S_INT;
          end else if (acc_ext) begin
            st_r <= S_ADDR;
          end
        end
        S_INT: begin
          st_r <= S_IDLE;
        end
        S_ADDR: begin
          if (cnt_r == ADDR_LAST) begin
            st_r  <= S_STRB;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_STRB: begin
          if (cnt_r == STRB_LAST) begin
            st_r  <= S_HOLD;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_HOLD: begin
          if (cnt_r == HOLD_LAST) begin
            st_r  <= S_IDLE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          st_r  <= S_IDLE;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // captured request for the off-chip cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_addr_r  <= 16'h0000;
      cur_wdata_r <= 8'h00;
      cur_write_r <= 1'b0;
      cur_ptr_r   <= 1'b0;
      last_ext_r  <= 1'b0;
    end else if (ce && accept) begin
      cur_addr_r  <= mv_addr;
      cur_wdata_r <= mv_wdata;
      cur_write_r <= mv_write;
      cur_ptr_r   <= mv_use_pointer;
      last_ext_r  <= !internal;
    end
  end

  // ==========================================================
  // pin synchroniser for read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lbp_meta_r <= 8'h00;
      lbp_sync_r <= 8'h00;
    end else if (ce) begin
      lbp_meta_r <= low_bus_port_i;
      lbp_sync_r <= lbp_meta_r;
    end
  end

  // ==========================================================
  // bus pins; a long strobe phase covers the two-flop read delay
  assign ale_idle = latch_supp ? (code_byte_move && !ale_r) : !ale_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ale_r    <= 1'b0;
      lbp_o_r  <= 8'h00;
      lbp_oe_r <= 1'b0;
      hap_o_r  <= 8'h00;
      hap_oe_r <= 1'b0;
      wr_n_r   <= 1'b1;
      rd_n_r   <= 1'b1;
    end else if (ce) begin
      case (st_r)
        S_IDLE: begin
          if (acc_ext) begin
            ale_r    <= 1'b1;
            lbp_o_r  <= mv_addr[7:0];
            lbp_oe_r <= 1'b1;
            hap_o_r  <= mv_addr[15:8];
            hap_oe_r <= mv_use_pointer;
          end else begin
            ale_r <= ale_idle;
          end
        end
        S_INT: begin
          ale_r <= ale_idle;
        end
        S_ADDR: begin
          if (cnt_r == ADDR_LAST) begin
            ale_r    <= 1'b0;
            wr_n_r   <= !cur_write_r;
            rd_n_r   <= cur_write_r;
            lbp_o_r  <= cur_wdata_r;
            lbp_oe_r <= cur_write_r;
          end
        end
        S_STRB: begin
          if (cnt_r == STRB_LAST) begin
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
          end
        end
        S_HOLD: begin
          if (cnt_r == HOLD_LAST) begin
            lbp_oe_r <= 1'b0;
            hap_oe_r <= 1'b0;
          end
        end
        default: begin
          wr_n_r <= 1'b1;
          rd_n_r <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // move response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
    end else if (ce) begin
      done_r <= 1'b0;
      if (st_r == S_INT) begin
        done_r  <= 1'b1;
        rdata_r <= ram_q;
      end else if (st_r == S_STRB && cnt_r == STRB_LAST && !cur_write_r) begin
        rdata_r <= lbp_sync_r;
      end else if (st_r == S_HOLD && cnt_r == HOLD_LAST) begin
        done_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // apb registers; zero wait states while enabled
  assign aux_hit  = (paddr == AUX_ADDR);
  assign stat_hit = (paddr == STAT_ADDR);
  assign pready   = ce;
  assign pslverr  = psel && penable && !(aux_hit || stat_hit);
  assign apb_wr   = psel && penable && pwrite && ce && aux_hit && pstrb[0];

  // reserved bits are not stored and read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_r <= AUX_RESET[1:0];
    end else if (apb_wr) begin
      aux_r <= pwdata[1:0] & AUX_IMPL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce && psel) begin
      prdata_r <= 32'h0000_0000;
      if (aux_hit) begin
        prdata_r[1:0] <= aux_r;
      end else if (stat_hit) begin
        prdata_r[STAT_BUSY_BIT] <= (st_r != S_IDLE);
        prdata_r[STAT_EXT_BIT]  <= last_ext_r;
      end
    end
  end

  assign prdata               = prdata_r;
  assign mv_done              = done_r;
  assign mv_rdata             = rdata_r;
  assign low_bus_port_o       = lbp_o_r;
  assign low_bus_port_oe      = lbp_oe_r;
  assign high_address_port_o  = hap_o_r;
  assign high_address_port_oe = hap_oe_r;
  assign wr_n                 = wr_n_r;
  assign rd_n                 = rd_n_r;
  assign ale                  = ale_r;

  // ==========================================================
  // checks
  chk_int_no_pins: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_int |=> (rd_n && wr_n && !low_bus_port_oe && !high_address_port_oe))
    else $error("on-chip access disturbed bus pins");

  chk_high_ptr_ext: assert property (
    @(posedge pclk) disable iff (!presetn)
    (accept && !bypass && mv_use_pointer && mv_addr >= ONCHIP_EXPANDED_RAM_BOUND) |=> st_r == S_ADDR)
    else $error("pointer move above ram not sent off-chip");

  chk_bypass_all_ext: assert property (
    @(posedge pclk) disable iff (!presetn)
    (accept && bypass) |=> (st_r == S_ADDR && ale))
    else $error("bypass move not sent off-chip");

  chk_ri_no_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r != S_IDLE && st_r != S_INT && !cur_ptr_r) |-> !high_address_port_oe)
    else $error("register-indexed move drove high port");

  chk_ptr_high_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r == S_STRB && cur_ptr_r) |->
      (high_address_port_oe && high_address_port_o == cur_addr_r[15:8]))
    else $error("high address byte wrong");

  chk_strobe_dir: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r == S_STRB) |-> (wr_n == !cur_write_r && rd_n == cur_write_r))
    else $error("strobe does not match direction");

  chk_low_ram_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (accept && !bypass && (!mv_use_pointer || mv_addr < ONCHIP_EXPANDED_RAM_BOUND))
      |=> (rd_n && wr_n) [*2])
    else $error("strobe on low address without bypass");

  chk_ale_free: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && st_r == S_IDLE && !acc_ext && !latch_supp) |=> ale != $past(ale))
    else $error("latch strobe not free running");

  chk_ale_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && st_r == S_IDLE && !acc_ext && latch_supp && !code_byte_move) |=> !ale)
    else $error("latch strobe active while suppressed");

  chk_ext_done: assert property (
    @(posedge pclk) disable iff (!presetn || !ce)
    acc_ext |-> ##[4:24] mv_done)
    else $error("off-chip move never completed");
endmodule // xdata_access_steering
`default_nettype wire

// ===== verification/ext_mem_model.sv
// behavioural external data memory on the multiplexed low port
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
  input  wire logic       pclk,
  input  wire logic       slow,
  input  wire logic [7:0] low_bus_port_o,
  input  wire logic       low_bus_port_oe,
  input  wire logic [7:0] high_address_port_o,
  input  wire logic       high_address_port_oe,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       ale,
  output logic      [7:0] low_bus_port_i
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_r;
  logic [7:0]  last_r = 8'h00;
  int          rd_cnt = 0;
  // ==========================================================
  // address taken at a clock edge while the latch strobe is high; sampling at the falling
  // strobe would race the swap of the low port to write data in the same time step
  always @(posedge pclk) begin
    if (ale && low_bus_port_oe) addr_r <= {high_address_port_oe ? high_address_port_o : 8'h00,
                                           low_bus_port_o};
  end
  always @(posedge wr_n) begin
    mem[addr_r] <= low_bus_port_oe ? low_bus_port_o : ~low_bus_port_o;
  end
  always @(posedge pclk) begin
    rd_cnt <= rd_n ? 0 : rd_cnt + 1;
    if (!rd_n) last_r <= mem[addr_r];
  end
  // no pull-ups: a released bus shows the inverse of the last byte; slow mode answers late
  assign low_bus_port_i = (!rd_n && (!slow || rd_cnt >= 1)) ? mem[addr_r] : ~last_r;
endmodule // ext_mem_model
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the external-data access steering block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import xdata_steer_pkg::*;
  // ==========================================================
  // signals
  logic        pclk, presetn, ce, psel, penable, pwrite, mv_req, mv_write, mv_ptr, cbm, slow;
  logic        pready, pslverr, mv_ready, mv_done, low_oe, high_oe, wr_n, rd_n, ale, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [15:0] mv_addr, a;
  logic [7:0]  mv_wdata, mv_rdata, low_i, low_o, high_o, aux;
  logic [7:0]  ref_mem [int];
  int          n_fail, tests_run, cycles, seed, n_rd, n_wr, n_hoe, n_loe, n_ale;

  xdata_access_steering dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mv_req(mv_req),
    .mv_write(mv_write), .mv_use_pointer(mv_ptr), .mv_addr(mv_addr), .mv_wdata(mv_wdata),
    .code_byte_move(cbm), .mv_ready(mv_ready), .mv_done(mv_done), .mv_rdata(mv_rdata),
    .low_bus_port_i(low_i), .low_bus_port_o(low_o), .low_bus_port_oe(low_oe),
    .high_address_port_o(high_o), .high_address_port_oe(high_oe), .wr_n(wr_n),
    .rd_n(rd_n), .ale(ale));
  ext_mem_model ext (.pclk(pclk), .slow(slow), .low_bus_port_o(low_o),
    .low_bus_port_oe(low_oe), .high_address_port_o(high_o), .high_address_port_oe(high_oe),
    .wr_n(wr_n), .rd_n(rd_n), .ale(ale), .low_bus_port_i(low_i));

  always #4 pclk = ~pclk;
  // ==========================================================
  // pin monitor on the falling edge, clear of the driving edge
  always @(negedge pclk) begin
    n_rd += !rd_n;
    n_wr += !wr_n;
    n_hoe += high_oe;
    n_loe += low_oe;
    n_ale += ale;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic set_aux(input logic [7:0] v);
    apb(1, AUX_ADDR, {24'h0, v});
    aux = v;
  endtask
  // ==========================================================
  // one move against the reference model; strobes counted per move
  task automatic mv(input logic w, input logic p, input logic [15:0] ad);
    logic       off;
    int         key, n;
    logic [7:0] d;
    d = 8'($random(seed));
    off = aux[BYPASS_BIT] || (p && ad >= ONCHIP_EXPANDED_RAM_BOUND);
    key = (off ? 32'h10000 : 0) + (p ? ad : {8'h00, ad[7:0]});
    n_rd = 0;
    n_wr = 0;
    n_hoe = 0;
    n_loe = 0;
    n_ale = 0;
    mv_req <= 1;
    mv_write <= w;
    mv_ptr <= p;
    mv_addr <= ad;
    mv_wdata <= d;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (mv_done !== 1'b1 && n < 50);
    mv_req <= 0;
    if (w) ref_mem[key] = d;
    else if (ref_mem.exists(key)) chk("load data", mv_rdata, ref_mem[key]);
    if (w && off) chk("ext store", ext.mem[key[15:0]], d);
    chk("rd cycles", n_rd, (off && !w) ? STRB_CYCLES : 0);
    chk("wr cycles", n_wr, (off && w) ? STRB_CYCLES : 0);
    chk("high port", 32'(n_hoe != 0), 32'(off && p));
    if (!off) chk("low port", n_loe, 0);
    if (aux[LATCH_SUPP_BIT]) chk("ale pulses", n_ale, off ? ADDR_CYCLES : 0);
    @(posedge pclk);
  endtask

  task automatic ale_run(input int exp);
    logic prev;
    int   t;
    repeat (2) @(posedge pclk);
    t = 0;
    prev = ale;
    repeat (6) begin
      @(posedge pclk);
      t += (ale !== prev);
      prev = ale;
    end
    chk("ale toggles", t, exp);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, mv_req, mv_write, mv_ptr, cbm, slow} = '0;
    ce = 1;
    pstrb = 4'hf;
    paddr = '0;
    pwdata = '0;
    mv_addr = '0;
    mv_wdata = '0;
    aux = '0;
    {n_fail, tests_run, cycles} = '0;
    seed = 32'h52ad;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, AUX_ADDR, 0);
    chk("aux reset", q, {24'h0, AUX_RESET});
    set_aux(8'hff);
    apb(0, AUX_ADDR, 0);
    chk("aux reserved", q, 32'h3);
    apb(0, 12'h100, 0);
    chk("unmapped err", e, 1);
    set_aux(0);
    ale_run(6);
    set_aux(1);
    ale_run(0);
    cbm <= 1;
    ale_run(6);
    cbm <= 0;
    set_aux(0);
    mv(1, 1, 16'h00a0);
    mv(0, 1, 16'h00a0);
    mv(1, 1, 16'h02ff);
    mv(0, 1, 16'h02ff);
    mv(1, 1, 16'h0300);
    mv(0, 1, 16'h0300);
    apb(0, STAT_ADDR, 0);
    chk("status ext", q[STAT_EXT_BIT], 1);
    mv(1, 0, 16'hff55);
    mv(0, 1, 16'h0055);
    apb(0, STAT_ADDR, 0);
    chk("status int", q[STAT_EXT_BIT], 0);
    slow <= 1;
    set_aux(2);
    mv(1, 0, 16'hff77);
    mv(0, 0, 16'hff77);
    mv(1, 1, 16'h00a0);
    mv(0, 1, 16'h00a0);
    set_aux(0);
    mv(0, 1, 16'h00a0);
    set_aux(1);
    mv(1, 1, 16'h1234);
    mv(0, 1, 16'h1234);
    mv(0, 0, 16'h0012);
    repeat (8) begin
      set_aux(8'($random(seed)) & 8'h03);
      a = 16'($random(seed));
      mv(1, a[0], a);
      mv(0, a[0], a);
    end
    stop_test();
  end
endmodule // testbench
`default_nettype wire
